// ===== pkg/ast_pkg.sv
// Package with register map, field positions, reset values and timing for the serial port.
package ast_pkg;
	// Byte addresses of the registers.
	localparam logic [7:0] AST_RXSC_ADDR = 8'h00;
	localparam logic [7:0] AST_TXBUF_ADDR = 8'h04;
	localparam logic [7:0] AST_TXSC_ADDR = 8'h08;
	localparam logic [7:0] AST_BAUD_ADDR = 8'h0c;
	localparam logic [7:0] AST_DIVH_ADDR = 8'h10;
	localparam logic [7:0] AST_DIVL_ADDR = 8'h14;
	localparam logic [7:0] AST_RXBUF_ADDR = 8'h18;
	localparam logic [7:0] AST_FLAG_ADDR = 8'h1c;
	// Receive status/control fields.
	localparam int AST_RX_SERIAL_PORT_ENABLE = 7;
	localparam int AST_RX_NINE = 6;
	localparam int AST_RX_CONT = 4;
	localparam int AST_RX_ADDR = 3;
	localparam int AST_RX_FRAMING_ERROR_FLAG = 2;
	localparam int AST_RX_OVERRUN_ERROR_FLAG = 1;
	localparam int AST_RX_BIT9 = 0;
	// Transmit status/control fields.
	localparam int AST_TX_NINE = 6;
	localparam int AST_TX_EN = 5;
	localparam int AST_TX_SYNC = 4;
	localparam int AST_TX_HISPD = 2;
	localparam int AST_TX_SEMPTY = 1;
	localparam int AST_TX_BIT9 = 0;
	// Baud control field.
	localparam int AST_BD_WIDE = 3;
	// Flag/enable register fields.
	localparam int AST_FL_RXF = 0;
	localparam int AST_FL_TXF = 1;
	localparam int AST_FL_RXIE = 2;
	localparam int AST_FL_TXIE = 3;
	localparam int AST_FL_RXIP = 4;
	// Writable masks and reset values.
	localparam logic [7:0] AST_RXSC_WMASK = 8'hd8;
	localparam logic [7:0] AST_TXSC_WMASK = 8'h75;
	localparam logic [7:0] AST_BAUD_WMASK = 8'h08;
	localparam logic [7:0] AST_REG_RESET = 8'h00;
	// Oversampling figures.
	localparam int AST_OVS = 16;
	localparam int AST_MID = 7;
	localparam logic [1:0] AST_PRE_X16 = 2'h0;
	localparam logic [1:0] AST_PRE_X64 = 2'h3;
	// Transmit and receive states.
	typedef enum logic [1:0] {AST_T_IDLE, AST_T_LOAD, AST_T_SHIFT} ast_tx_type;
	typedef enum logic [1:0] {AST_R_IDLE, AST_R_START, AST_R_DATA, AST_R_STOP} ast_rx_type;
endpackage

// ===== rtl/ast_serial.sv
// Asynchronous serial transceiver with APB register access.
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module ast_serial (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial line.
	input wire logic rxPin,
	output logic txPin,
	// Events.
	output logic txIrq,
	output logic rxIrq
);
	import ast_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic [7:0] rxscFf, txscFf, baudFf, divHFf, divLFf, txBufFf, rxBufFf;
	logic rxIeFf, txIeFf, rxIpFf;
	logic txFlagFf, txFullFf, ferrFf, oerrFf, rxBit9Ff, rxFlagFf;
	logic txValidDlyFf;
	logic shiftEmpty;
	logic apbWr, apbRd;
	logic txEnable, rxEnable;

	// One-cycle access phase completes every transfer.
	assign apbWr = psel && penable && pwrite;
	assign apbRd = psel && penable && !pwrite;
	assign txEnable = rxscFf[AST_RX_SERIAL_PORT_ENABLE] && !txscFf[AST_TX_SYNC] && txscFf[AST_TX_EN];
	assign rxEnable = rxscFf[AST_RX_SERIAL_PORT_ENABLE] && !txscFf[AST_TX_SYNC] && rxscFf[AST_RX_CONT];

	function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
		hit = (a == b);
	endfunction

	// Control registers written by software, the status/control and baud registers through masks.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rxscFf <= AST_REG_RESET;
			txscFf <= AST_REG_RESET;
			baudFf <= AST_REG_RESET;
			divHFf <= AST_REG_RESET;
			divLFf <= AST_REG_RESET;
			rxIeFf <= 1'b0;
			txIeFf <= 1'b0;
			rxIpFf <= 1'b0;
		end else if (apbWr) begin
			if (hit(paddr, AST_RXSC_ADDR)) rxscFf <= pwdata[7:0] & AST_RXSC_WMASK;
			if (hit(paddr, AST_TXSC_ADDR)) txscFf <= pwdata[7:0] & AST_TXSC_WMASK;
			if (hit(paddr, AST_BAUD_ADDR)) baudFf <= pwdata[7:0] & AST_BAUD_WMASK;
			if (hit(paddr, AST_DIVH_ADDR)) divHFf <= pwdata[7:0];
			if (hit(paddr, AST_DIVL_ADDR)) divLFf <= pwdata[7:0];
			if (hit(paddr, AST_FLAG_ADDR)) begin
				rxIeFf <= pwdata[AST_FL_RXIE];
				txIeFf <= pwdata[AST_FL_TXIE];
				rxIpFf <= pwdata[AST_FL_RXIP];
			end
		end
	end

	// Read mux; unmapped addresses and unused bits read as zero.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			if (psel && !penable && !pwrite) begin
				unique case (paddr)
					AST_RXSC_ADDR: prdata[7:0] <= rxscFf | {5'h0, ferrFf, oerrFf, rxBit9Ff};
					AST_TXBUF_ADDR: prdata[7:0] <= txBufFf;
					AST_TXSC_ADDR: prdata[7:0] <= txscFf | {6'h0, shiftEmpty, 1'b0};
					AST_BAUD_ADDR: prdata[7:0] <= baudFf;
					AST_DIVH_ADDR: prdata[7:0] <= divHFf;
					AST_DIVL_ADDR: prdata[7:0] <= divLFf;
					AST_RXBUF_ADDR: prdata[7:0] <= rxBufFf;
					AST_FLAG_ADDR: prdata[7:0] <= {3'h0, rxIpFf, txIeFf, rxIeFf, txFlagFf, rxFlagFf};
					default: prdata <= 32'h0;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Baud generator: shared divider, then prescale to a x16 tick.
	logic [15:0] divCntFf;
	logic [1:0] preCntFf;
	logic [15:0] divLoad;
	logic divHit, tick16;
	logic [1:0] preTop;
	assign divLoad = baudFf[AST_BD_WIDE] ? {divHFf, divLFf} : {8'h0, divLFf};
	assign divHit = (divCntFf == 16'h0);
	// x16 when high speed or the wide divider is selected, x64 only when both are clear.
	assign preTop = (txscFf[AST_TX_HISPD] || baudFf[AST_BD_WIDE]) ? AST_PRE_X16 : AST_PRE_X64;
	assign tick16 = divHit && (preCntFf == 2'h0);

	// Divider counts down and reloads; one generator for both directions.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			divCntFf <= 16'h0;
			preCntFf <= 2'h0;
		end else if (!rxscFf[AST_RX_SERIAL_PORT_ENABLE]) begin
			divCntFf <= 16'h0;
			preCntFf <= 2'h0;
		end else if (divHit) begin
			divCntFf <= divLoad;
			preCntFf <= (preCntFf == 2'h0) ? preTop : preCntFf - 2'h1;
		end else begin
			divCntFf <= divCntFf - 16'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmitter.
	ast_tx_type txStateFf;
	logic [9:0] tsrFf;
	logic [3:0] txBitsFf, txSubFf;
	logic txLoad, txBufWr;
	assign txBufWr = apbWr && hit(paddr, AST_TXBUF_ADDR);
	assign shiftEmpty = (txStateFf != AST_T_SHIFT);
	assign txLoad = (txStateFf == AST_T_LOAD);

	// Transmit buffer and its full flag.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			txBufFf <= AST_REG_RESET;
			txFullFf <= 1'b0;
		end else begin
			if (txLoad) txFullFf <= 1'b0;
			if (txBufWr) begin
				txBufFf <= pwdata[7:0];
				txFullFf <= 1'b1;
			end
			if (!txEnable) txFullFf <= 1'b0;
		end
	end

	// Empty flag: set on enable or move, cleared two cycles after a buffer write.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			txFlagFf <= 1'b0;
			txValidDlyFf <= 1'b0;
		end else begin
			txValidDlyFf <= txBufWr;
			if (txValidDlyFf && txFullFf) txFlagFf <= 1'b0;
			if (apbWr && hit(paddr, AST_TXSC_ADDR) && pwdata[AST_TX_EN] && !txscFf[AST_TX_EN])
				txFlagFf <= 1'b1;
			if (txLoad) txFlagFf <= 1'b1;
		end
	end

	// Shift register: loads only when idle after the stop bit.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			txStateFf <= AST_T_IDLE;
			tsrFf <= 10'h3ff;
			txBitsFf <= 4'h0;
			txSubFf <= 4'h0;
			txPin <= 1'b1;
		end else if (!txEnable) begin
			txStateFf <= AST_T_IDLE;
			txPin <= 1'b1;
		end else begin
			unique case (txStateFf)
				AST_T_IDLE: if (txFullFf && !txBufWr) txStateFf <= AST_T_LOAD;
				AST_T_LOAD: begin
					// Start bit goes out now; ninth bit (parity by software) sits above data.
					tsrFf <= txscFf[AST_TX_NINE] ? {1'b1, txscFf[AST_TX_BIT9], txBufFf} :
						{2'b11, txBufFf};
					txPin <= 1'b0;
					txStateFf <= AST_T_SHIFT;
					txBitsFf <= txscFf[AST_TX_NINE] ? 4'ha : 4'h9;
					txSubFf <= 4'h0;
				end
				AST_T_SHIFT: if (tick16) begin
					txSubFf <= txSubFf + 4'h1;
					if (txSubFf == 4'hf) begin
						if (txBitsFf == 4'h0) begin
							txStateFf <= AST_T_IDLE;
						end else begin
							txBitsFf <= txBitsFf - 4'h1;
							txPin <= tsrFf[0];
							tsrFf <= {1'b1, tsrFf[9:1]};
						end
					end
				end
				default: txStateFf <= AST_T_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receiver: pin synchroniser, x16 sampler, bit-rate shifter.
	logic [2:0] rxSyncFf;
	logic rxLineFf;
	ast_rx_type rxStateFf;
	logic [3:0] rxSubFf, rxBitsFf;
	logic [8:0] rsrFf;
	logic rxDone, rxKeep;

	// Three stages; the line level changes when stages two and three agree.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rxSyncFf <= 3'h7;
			rxLineFf <= 1'b1;
		end else begin
			rxSyncFf <= {rxSyncFf[1:0], rxPin};
			if (rxSyncFf[1] == rxSyncFf[2]) rxLineFf <= rxSyncFf[2];
		end
	end

	// Gated by the enable so a frame cut by clearing reception cannot set an error.
	assign rxDone = rxEnable && (rxStateFf == AST_R_STOP) && tick16 && (rxSubFf == 4'hf);
	// Address detect drops frames whose ninth bit is zero.
	assign rxKeep = !(rxscFf[AST_RX_NINE] && rxscFf[AST_RX_ADDR] && !rsrFf[8]);

	// Frame state machine, sampling mid-bit on the x16 tick.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rxStateFf <= AST_R_IDLE;
			rxSubFf <= 4'h0;
			rxBitsFf <= 4'h0;
			rsrFf <= 9'h0;
		end else if (!rxEnable) begin
			rxStateFf <= AST_R_IDLE;
		end else if (tick16) begin
			rxSubFf <= rxSubFf + 4'h1;
			unique case (rxStateFf)
				AST_R_IDLE: begin
					rxSubFf <= 4'h0;
					if (!rxLineFf) rxStateFf <= AST_R_START;
				end
				AST_R_START: if (rxSubFf == 4'(AST_MID)) begin
					rxSubFf <= 4'h0;
					rxBitsFf <= rxscFf[AST_RX_NINE] ? 4'h9 : 4'h8;
					rxStateFf <= rxLineFf ? AST_R_IDLE : AST_R_DATA;
				end
				AST_R_DATA: if (rxSubFf == 4'hf) begin
					rsrFf <= rxscFf[AST_RX_NINE] ? {rxLineFf, rsrFf[8:1]} :
						{1'b0, rxLineFf, rsrFf[7:1]};
					rxBitsFf <= rxBitsFf - 4'h1;
					if (rxBitsFf == 4'h1) rxStateFf <= AST_R_STOP;
				end
				AST_R_STOP: if (rxSubFf == 4'hf) rxStateFf <= AST_R_IDLE;
			endcase
		end
	end

	// Receive buffer, ninth bit, flag and errors; set wins over clear.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rxBufFf <= AST_REG_RESET;
			rxBit9Ff <= 1'b0;
			rxFlagFf <= 1'b0;
			ferrFf <= 1'b0;
			oerrFf <= 1'b0;
		end else begin
			if (apbRd && hit(paddr, AST_RXBUF_ADDR)) rxFlagFf <= 1'b0;
			if (!rxscFf[AST_RX_CONT]) begin
				ferrFf <= 1'b0;
				oerrFf <= 1'b0;
			end
			if (rxDone && rxKeep) begin
				if (rxFlagFf && !(apbRd && hit(paddr, AST_RXBUF_ADDR))) begin
					oerrFf <= 1'b1;
				end else begin
					rxBufFf <= rsrFf[7:0];
					rxBit9Ff <= rsrFf[8];
					ferrFf <= !rxLineFf;
					rxFlagFf <= 1'b1;
				end
			end
		end
	end

	// Event outputs gated by their enables.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			txIrq <= 1'b0;
			rxIrq <= 1'b0;
		end else begin
			txIrq <= txFlagFf && txIeFf;
			rxIrq <= rxFlagFf && rxIeFf;
		end
	end

	////////////////////////////////////////////////////////////////////////
	chk_move_sets_flag: assert property (@(posedge clk) disable iff (rst)
		(txLoad && !txBufWr) |=> txFlagFf && !txFullFf) else $error("move did not set flag");
	chk_flag_not_writable: assert property (@(posedge clk) disable iff (rst)
		$fell(txFlagFf) |-> $past(txValidDlyFf)) else $error("flag cleared oddly");
	chk_clear_two_cycles: assert property (@(posedge clk) disable iff (rst)
		(txBufWr && txEnable && txFlagFf && txStateFf == AST_T_SHIFT) |=> txFlagFf ##1 !txFlagFf)
		else $error("flag clear timing wrong");
	chk_load_after_stop: assert property (@(posedge clk) disable iff (rst)
		txLoad |-> $past(txStateFf) == AST_T_IDLE) else $error("load while shifting");
	chk_idle_line_high: assert property (@(posedge clk) disable iff (rst)
		(txStateFf == AST_T_IDLE) |-> txPin) else $error("idle line not high");
	chk_rxbuf_read_clear: assert property (@(posedge clk) disable iff (rst)
		(apbRd && hit(paddr, AST_RXBUF_ADDR) && !rxDone) |=> !rxFlagFf)
		else $error("read did not clear flag");
	chk_error_cleared: assert property (@(posedge clk) disable iff (rst)
		!rxscFf[AST_RX_CONT] |=> !ferrFf && !oerrFf) else $error("errors not cleared");
	chk_addr_filter: assert property (@(posedge clk) disable iff (rst)
		(rxDone && !rxKeep && !rxFlagFf) |=> !rxFlagFf) else $error("address frame leaked");
	chk_overrun_set: assert property (@(posedge clk) disable iff (rst)
		(rxDone && rxKeep && rxFlagFf && !apbRd && rxscFf[AST_RX_CONT]) |=> oerrFf)
		else $error("overrun missed");
	cov_tx_frame: cover property (@(posedge clk) disable iff (rst) txLoad ##[1:1000] shiftEmpty);
	cov_rx_frame: cover property (@(posedge clk) disable iff (rst) rxDone && rxKeep);
	cov_overrun: cover property (@(posedge clk) disable iff (rst) $rose(oerrFf));
	cov_framing: cover property (@(posedge clk) disable iff (rst) $rose(ferrFf));
endmodule

// ===== test/ast_remote_node.sv
// Remote asynchronous serial node facing the port's line pins.
`timescale 1ns/1ps
module ast_remote_node (
	// Clock.
	input wire logic clk,
	// Serial line.
	input wire logic lineIn,
	output logic lineOut
);
	// The line idles high between frames.
	initial lineOut = 1'b1;
	////////////////////////////////////////////////////////////////////////////////
	// Sends start, data least significant bit first, then a stop bit of the given level.
	task automatic sendFrame(input logic [8:0] d, input int nBits, input logic stopLvl,
		input int bitClk);
		@(posedge clk);
		lineOut <= 1'b0;
		repeat (bitClk) @(posedge clk);
		for (int i = 0; i < nBits; i++) begin
			lineOut <= d[i];
			repeat (bitClk) @(posedge clk);
		end
		lineOut <= stopLvl;
		repeat (bitClk) @(posedge clk);
		lineOut <= 1'b1;
	endtask
	// Waits a bounded time for a start bit, then samples each bit at its middle.
	task automatic recvFrame(output logic [8:0] d, output logic stopBit, output logic seen,
		input int nBits, input int bitClk);
		int n;
		n = 0;
		d = 9'h000;
		while (lineIn !== 1'b0 && n < 8000) begin
			@(posedge clk);
			n++;
		end
		seen = (n < 8000);
		repeat (bitClk / 2) @(posedge clk);
		for (int i = 0; i < nBits; i++) begin
			repeat (bitClk) @(posedge clk);
			d[i] = lineIn;
		end
		repeat (bitClk) @(posedge clk);
		stopBit = lineIn;
	endtask
endmodule

// ===== test/ast_serial_bench.sv
// Self-checking bench for the asynchronous serial port.
`timescale 1ns/1ps
module ast_serial_bench;
	import ast_pkg::*;
	// Bench signals.
	logic clk, rst, psel, penable, pwrite, pready, pslverr, rxPin, txPin, txIrq, rxIrq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic [8:0] g0, g1;
	logic s0, s1, k0, k1;
	int miscompares, total_checks;
	// Design and remote node.
	ast_serial u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rxPin(rxPin), .txPin(txPin), .txIrq(txIrq), .rxIrq(rxIrq));
	ast_remote_node u_node (.clk(clk), .lineIn(txPin), .lineOut(rxPin));
	// Clock with a 50 ns period.
	always #25 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////////
	// Compares one value and counts the comparison.
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// One APB transfer held until pready; read data lands in rdv.
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rdv = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16) begin
			miscompares++;
			end_sim();
		end
	endtask
	// Write, checked read and bounded poll of one register bit.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
		apb(a, 1'b0, 32'h0);
		check(rdv, e);
		check({31'h0, pslverr}, 32'h0);
	endtask
	task automatic pollBit(input logic [7:0] a, input int b);
		int n;
		n = 0;
		do begin
			apb(a, 1'b0, 32'h0);
			n++;
		end while (rdv[b] !== 1'b1 && n < 600);
		if (n >= 600) begin
			miscompares++;
			end_sim();
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Reset values, unused bits, unmapped place, then port set-up and transmit enable.
	task automatic sSetup();
		rdChk(AST_RXSC_ADDR, 32'h0);
		rdChk(AST_TXSC_ADDR, 32'h02);
		rdChk(8'h20, 32'h0);
		wr(AST_BAUD_ADDR, 32'hffffffff);
		rdChk(AST_BAUD_ADDR, 32'h08);
		wr(AST_BAUD_ADDR, 32'h0);
		wr(AST_DIVH_ADDR, 32'h0);
		wr(AST_DIVL_ADDR, 32'h1);
		wr(AST_TXSC_ADDR, 32'h04);
		wr(AST_FLAG_ADDR, 32'h0c);
		wr(AST_RXSC_ADDR, 32'h90);
		wr(AST_TXSC_ADDR, 32'h24);
		rdChk(AST_FLAG_ADDR, 32'h0e);
		wr(AST_FLAG_ADDR, 32'h0c);
		rdChk(AST_FLAG_ADDR, 32'h0e);
		check(32'(txIrq), 32'h1);
	endtask
	// Two bytes back to back, then a nine-bit frame.
	task automatic sTx();
		fork
			begin
				u_node.recvFrame(g0, s0, k0, 8, 32);
				u_node.recvFrame(g1, s1, k1, 8, 32);
			end
			begin
				wr(AST_TXBUF_ADDR, 32'ha5);
				wr(AST_TXBUF_ADDR, 32'h3c);
				rdChk(AST_FLAG_ADDR, 32'h0c);
				rdChk(AST_TXSC_ADDR, 32'h24);
			end
		join
		check({21'h0, k0, s0, g0}, {21'h0, 2'h3, 9'h0a5});
		check({21'h0, k1, s1, g1}, {21'h0, 2'h3, 9'h03c});
		pollBit(AST_TXSC_ADDR, AST_TX_SEMPTY);
		rdChk(AST_FLAG_ADDR, 32'h0e);
		wr(AST_TXSC_ADDR, 32'h65);
		fork
			u_node.recvFrame(g0, s0, k0, 9, 32);
			wr(AST_TXBUF_ADDR, 32'h5a);
		join
		check({21'h0, k0, s0, g0}, {21'h0, 2'h3, 9'h15a});
		pollBit(AST_TXSC_ADDR, AST_TX_SEMPTY);
		wr(AST_TXSC_ADDR, 32'h24);
	endtask
	// Plain reception, an overrun error and its clearing, then a framing error.
	task automatic sRx();
		u_node.sendFrame(9'h096, 8, 1'b1, 32);
		pollBit(AST_FLAG_ADDR, AST_FL_RXF);
		check(32'(rxIrq), 32'h1);
		rdChk(AST_RXSC_ADDR, 32'h90);
		rdChk(AST_RXBUF_ADDR, 32'h96);
		rdChk(AST_FLAG_ADDR, 32'h0e);
		u_node.sendFrame(9'h011, 8, 1'b1, 32);
		u_node.sendFrame(9'h022, 8, 1'b1, 32);
		pollBit(AST_RXSC_ADDR, AST_RX_OVERRUN_ERROR_FLAG);
		rdChk(AST_RXSC_ADDR, 32'h92);
		rdChk(AST_RXBUF_ADDR, 32'h11);
		wr(AST_RXSC_ADDR, 32'h80);
		rdChk(AST_RXSC_ADDR, 32'h80);
		wr(AST_RXSC_ADDR, 32'h90);
		u_node.sendFrame(9'h055, 8, 1'b0, 32);
		pollBit(AST_FLAG_ADDR, AST_FL_RXF);
		rdChk(AST_RXSC_ADDR, 32'h94);
		rdChk(AST_RXBUF_ADDR, 32'h55);
	endtask
	// Address filtering on the ninth bit, then open reception.
	task automatic sAddr();
		wr(AST_RXSC_ADDR, 32'hd8);
		u_node.sendFrame(9'h033, 9, 1'b1, 32);
		repeat (64) @(posedge clk);
		rdChk(AST_FLAG_ADDR, 32'h0e);
		u_node.sendFrame(9'h1a7, 9, 1'b1, 32);
		pollBit(AST_FLAG_ADDR, AST_FL_RXF);
		rdChk(AST_RXSC_ADDR, 32'hd9);
		rdChk(AST_RXBUF_ADDR, 32'ha7);
		wr(AST_RXSC_ADDR, 32'hd0);
		u_node.sendFrame(9'h044, 9, 1'b1, 32);
		pollBit(AST_FLAG_ADDR, AST_FL_RXF);
		rdChk(AST_RXSC_ADDR, 32'hd0);
		rdChk(AST_RXBUF_ADDR, 32'h44);
	endtask
	// Narrow divider (high byte ignored) at x64 both ways, then wide divider at x16.
	task automatic sSlow();
		wr(AST_DIVH_ADDR, 32'hff);
		wr(AST_TXSC_ADDR, 32'h20);
		wr(AST_RXSC_ADDR, 32'h90);
		fork
			u_node.recvFrame(g0, s0, k0, 8, 128);
			u_node.sendFrame(9'h07e, 8, 1'b1, 128);
			wr(AST_TXBUF_ADDR, 32'h81);
		join
		check({21'h0, k0, s0, g0}, {21'h0, 2'h3, 9'h081});
		pollBit(AST_FLAG_ADDR, AST_FL_RXF);
		rdChk(AST_RXBUF_ADDR, 32'h7e);
		pollBit(AST_TXSC_ADDR, AST_TX_SEMPTY);
		wr(AST_DIVH_ADDR, 32'h01);
		wr(AST_BAUD_ADDR, 32'h08);
		fork
			u_node.recvFrame(g1, s1, k1, 8, 4128);
			wr(AST_TXBUF_ADDR, 32'hc3);
		join
		check({21'h0, k1, s1, g1}, {21'h0, 2'h3, 9'h0c3});
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: reset for ten cycles, then every scenario in turn.
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		miscompares = 0;
		total_checks = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		sSetup();
		sTx();
		sRx();
		sAddr();
		sSlow();
		end_sim();
	end
endmodule
